// ---- common/pot_cmd_map.vh ----
// register encodings and timing constants for the pot command unit
`ifndef POT_CMD_MAP_VH
`define POT_CMD_MAP_VH
// identification byte
// device type code; the value is arbitrary
`define TYPE_CODE 4'ha
`define ID_FIXED_ZERO 2'h0
// opcodes, instruction byte bits 7:5
`define OP_STATUS 3'h2
`define OP_READ_WIPER 3'h4
`define OP_WRITE_WIPER 3'h5
`define OP_READ_STORED 3'h5
`define OP_WRITE_STORED 3'h6
`define OP_COPY_TO_WIPER 3'h6
`define OP_COPY_TO_STORED 3'h7
`define STATUS_TAIL 2'h1
// frame lengths in bits
`define BITS_SHORT 6'h10
`define BITS_LONG 6'h20
`define BITS_ID 6'h08
// nonvolatile write time, microseconds, and clock rate in MHz
`define NV_WRITE_US 10000
`define CLK_MHZ 200
// wiper settle time in ns
`define SETTLE_NS 200
`define WIDTH_POS 10
`define RESET_POS 10'h000
`endif

// ---- rtl/tap_decoder.v ----
// one-hot tap switch decoder
`timescale 1ns/1ps
module tap_decoder #(
    parameter W = 10
) (
    input wire clk,
    input wire rst,
    input wire [W-1:0] pos,
    output reg [(1<<W)-1:0] taps
);
    // =========================================
    // decode
    genvar i;
    generate
        for (i = 0; i < (1<<W); i = i + 1) begin : g_tap
            always @(posedge clk) begin
                if (rst)
                    taps[i] <= (i == 0);
                else
                    taps[i] <= (pos == i);
            end
        end
    endgenerate
endmodule

// ---- rtl/spi_pot_command_unit.v ----
// serial command decoder and registers of the digital potentiometer
//
// Operation
// - sample serial input on clock rising
// - wiper decodes to exactly one tap
// - wiper changed only by write, copy, power-up
// - four nonvolatile ten-bit stored registers
// - stored register change takes nonvolatile write time
// - busy bit set during nonvolatile write
// - first byte upper nibble is type code
// - address bit must match address pin
// - last id bit: 1 read, 0 write
// - opcode top three bits, two select bits
// - wiper read 100, write 101
// - stored read 101, write 110
// - copy to wiper 110, to stored 111
// - status read returns busy bit
// - register commands are four bytes
// - copy commands are two bytes
// - copy to stored is nonvolatile; wiper settles
// - nonvolatile save starts at select rise
// - serial output driven only for read data
// - read data shifted on clock falling
// - deselected: output off, standby
// - pause freezes sequence without reset
// - write lock low blocks nonvolatile writes
`timescale 1ns/1ps
`include "pot_cmd_map.vh"
module spi_pot_command_unit #(
    parameter W = `WIDTH_POS,
    parameter NV_CYCLES = `NV_WRITE_US * `CLK_MHZ,
    parameter SETTLE_CYCLES = (`SETTLE_NS * `CLK_MHZ) / 1000
) (
    input wire clk,
    input wire rst,
    input wire sck,
    input wire si,
    input wire cs_n,
    input wire hold_n,
    input wire wp_n,
    input wire slave_addr_bit,
    output reg so_out,
    output reg so_oe_n,
    output reg write_status_reg,
    output reg [W-1:0] wiper_position_reg,
    output wire [(1<<W)-1:0] tap_select
);
    // =========================================
    // input synchronisers
    reg [5:0] sync1;
    reg [5:0] sync2;
    reg sck_d;
    always @(posedge clk) begin
        sync1 <= {sck, si, cs_n, hold_n, wp_n, slave_addr_bit};
        sync2 <= sync1;
    end
    // only the second stage is read, the first may be metastable
    wire sck_q = sync2[5];
    wire si_q = sync2[4];
    wire cs_q = sync2[3];
    wire hold_q = sync2[2];
    wire wp_q = sync2[1];
    wire addr_q = sync2[0];
    always @(posedge clk) begin
        if (rst)
            sck_d <= 1'b0;
        else
            sck_d <= sck_q;
    end
    wire active = !cs_q && hold_q;
    wire rise = active && sck_q && !sck_d;
    wire fall = active && !sck_q && sck_d;

    // =========================================
    // frame state
    localparam S_IDLE = 4'b0001;
    localparam S_RECV = 4'b0010;
    localparam S_DROP = 4'b0100;
    localparam S_DONE = 4'b1000;
    reg [3:0] state;
    reg [5:0] count;
    reg [7:0] id_byte;
    reg [7:0] instr;
    reg [15:0] data;
    reg [15:0] out_sr;
    reg reading;
    reg [W-1:0] stored_position_reg [0:3];
    reg [W-1:0] pending_val;
    reg [1:0] pending_sel;
    reg pending_nv;
    reg [31:0] nv_count;
    reg [15:0] settle_count;
    reg [W-1:0] settle_val;
    reg settling;
    // settle count is cut to sixteen bits on purpose
    wire [31:0] settle_init = SETTLE_CYCLES;

    wire [2:0] opcode = instr[7:5];
    wire reg_select_hi = instr[3];
    wire reg_select_lo = instr[2];
    wire [1:0] sel = {reg_select_hi, reg_select_lo};
    wire dir_read = id_byte[0];
    // instruction byte is complete when count reaches 16
    wire [7:0] next_instr = {instr[6:0], si_q};
    wire [2:0] nop = next_instr[7:5];
    wire [1:0] nsel = next_instr[3:2];
    wire sel_zero = (next_instr[3:2] == 2'h0);
    wire tail_ok = (next_instr[1:0] == 2'h0) && !next_instr[4];
    wire is_status = dir_read && nop == `OP_STATUS && sel_zero
                     && next_instr[1:0] == `STATUS_TAIL;
    wire busy = write_status_reg;

    always @(posedge clk) begin
        if (rst) begin
            state <= S_IDLE;
            count <= 6'h00;
            id_byte <= 8'h00;
            instr <= 8'h00;
            data <= 16'h0000;
            out_sr <= 16'h0000;
            reading <= 1'b0;
            so_oe_n <= 1'b1;
            so_out <= 1'b0;
            pending_nv <= 1'b0;
            pending_sel <= 2'h0;
            pending_val <= `RESET_POS;
            settling <= 1'b0;
            settle_val <= `RESET_POS;
            settle_count <= 16'h0000;
            wiper_position_reg <= `RESET_POS;
            write_status_reg <= 1'b0;
            nv_count <= 32'h0;
            stored_position_reg[0] <= `RESET_POS;
            stored_position_reg[1] <= `RESET_POS;
            stored_position_reg[2] <= `RESET_POS;
            stored_position_reg[3] <= `RESET_POS;
        end else begin
            if (cs_q) begin
                state <= S_IDLE;
                count <= 6'h00;
                reading <= 1'b0;
                so_oe_n <= 1'b1;
                // save on select rise, lock, timing
                if (pending_nv && wp_q && !busy) begin
                    stored_position_reg[pending_sel] <= pending_val;
                    write_status_reg <= 1'b1;
                    nv_count <= NV_CYCLES - 1;
                end
                pending_nv <= 1'b0;
            end else if (rise && (state == S_IDLE || state == S_RECV)) begin
                state <= S_RECV;
                count <= count + 6'h01;
                if (count < `BITS_ID) begin
                    id_byte <= {id_byte[6:0], si_q};
                end else if (count < `BITS_SHORT) begin
                    instr <= next_instr;
                end else begin
                    data <= {data[14:0], si_q};
                end
                if (count == `BITS_ID - 6'h01) begin
                    if (id_byte[6:3] != `TYPE_CODE
                        || id_byte[2:1] != `ID_FIXED_ZERO
                        || id_byte[0] != addr_q)
                        state <= S_DROP;
                end
                if (count == `BITS_SHORT - 6'h01) begin
                    if (busy && !is_status) begin
                        state <= S_DROP;
                    end else if (is_status) begin
                        reading <= 1'b1;
                        out_sr <= {15'h0000, busy};
                    end else if (!tail_ok) begin
                        state <= S_DROP;
                    end else if (dir_read && nop == `OP_READ_WIPER
                                 && sel_zero) begin
                        reading <= 1'b1;
                        out_sr <= {6'h00, wiper_position_reg};
                    end else if (dir_read && nop == `OP_READ_STORED) begin
                        reading <= 1'b1;
                        out_sr <= {6'h00, stored_position_reg[nsel]};
                    end else if (dir_read && nop == `OP_COPY_TO_WIPER) begin
                        // copy to wiper, settle, two bytes
                        settle_val <= stored_position_reg[nsel];
                        settling <= 1'b1;
                        settle_count <= settle_init[15:0];
                        state <= S_DONE;
                    end else if (!dir_read && nop == `OP_COPY_TO_STORED) begin
                        pending_val <= wiper_position_reg;
                        pending_sel <= nsel;
                        pending_nv <= 1'b1;
                        state <= S_DONE;
                    end else if (!dir_read
                                 && !(nop == `OP_WRITE_WIPER && sel_zero)
                                 && nop != `OP_WRITE_STORED) begin
                        state <= S_DROP;
                    end
                end
                if (count == `BITS_LONG - 6'h01) begin
                    state <= S_DONE;
                    reading <= 1'b0;
                    if (!dir_read && opcode == `OP_WRITE_WIPER)
                        wiper_position_reg <= {data[W-2:0], si_q};
                    else if (!dir_read && opcode == `OP_WRITE_STORED) begin
                        pending_val <= {data[W-2:0], si_q};
                        pending_sel <= sel;
                        pending_nv <= 1'b1;
                    end
                end
            end else if (rise) begin
                // extra bits after a finished frame cancel its pending save
                if (state == S_DONE && !reading)
                    pending_nv <= 1'b0;
            end
            // drive only while reading, on fall
            if (!cs_q && fall && reading && count >= `BITS_SHORT) begin
                so_oe_n <= 1'b0;
                so_out <= out_sr[15];
                out_sr <= {out_sr[14:0], 1'b0};
            end else if (!reading || state == S_DROP) begin
                so_oe_n <= 1'b1;
            end
            if (write_status_reg && !cs_q) begin
                if (nv_count == 32'h0)
                    write_status_reg <= 1'b0;
                else
                    nv_count <= nv_count - 32'h1;
            end else if (write_status_reg) begin
                if (nv_count == 32'h0)
                    write_status_reg <= 1'b0;
                else if (!(pending_nv && wp_q))
                    nv_count <= nv_count - 32'h1;
            end
            if (settling) begin
                if (settle_count == 16'h0000) begin
                    settling <= 1'b0;
                    wiper_position_reg <= settle_val;
                end else begin
                    settle_count <= settle_count - 16'h0001;
                end
            end
        end
    end

    // =========================================
    // tap switches
    tap_decoder #(.W(W)) u_taps (
        .clk(clk),
        .rst(rst),
        .pos(wiper_position_reg),
        .taps(tap_select)
    );
endmodule

// ---- sim/pot_unit_asserts.sv ----
// port checker for the pot command unit
`timescale 1ns/1ps
module pot_unit_asserts #(
    parameter W = 10,
    parameter NV_CYCLES = 200
) (
    input wire clk,
    input wire rst,
    input wire sck,
    input wire cs_n,
    input wire so_out,
    input wire so_oe_n,
    input wire write_status_reg,
    input wire [W-1:0] wiper_position_reg,
    input wire [(1<<W)-1:0] tap_select
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    integer busy_cnt;
    // counter, since the busy span is far beyond a repetition
    always @(posedge clk) begin
        if (rst || !write_status_reg) busy_cnt <= 0;
        else busy_cnt <= busy_cnt + 1;
    end
    // ========================================
    // properties
    chk_tap_onehot: assert property ($onehot(tap_select))
        else $error("taps not one-hot");
    chk_tap_follow: assert property (!$past(rst) |->
        tap_select[$past(wiper_position_reg)]) else $error("tap off");
    chk_desel_off: assert property (cs_n [*5] |-> so_oe_n)
        else $error("so driven while deselected");
    chk_drive_sel: assert property ($fell(so_oe_n) |-> !cs_n)
        else $error("so driven without select");
    chk_so_shift: assert property (!so_oe_n && !$past(so_oe_n) &&
        $changed(so_out) |-> !sck) else $error("so moved, clock high");
    chk_busy_bound: assert property (busy_cnt <= NV_CYCLES)
        else $error("busy too long");
    chk_busy_start: assert property ($rose(write_status_reg) |-> cs_n)
        else $error("save started while selected");
    chk_busy_wiper: assert property (write_status_reg &&
        $past(write_status_reg) |-> $stable(wiper_position_reg))
        else $error("wiper moved while busy");
    cover property ($rose(write_status_reg));
    cover property ($fell(so_oe_n));
    cover property ($changed(wiper_position_reg));
endmodule
bind spi_pot_command_unit pot_unit_asserts #(.W(W),
    .NV_CYCLES(NV_CYCLES)) pot_unit_asserts_i (.clk(clk), .rst(rst),
    .sck(sck), .cs_n(cs_n), .so_out(so_out), .so_oe_n(so_oe_n),
    .write_status_reg(write_status_reg),
    .wiper_position_reg(wiper_position_reg), .tap_select(tap_select));

// ---- sim/spi_host_model.sv ----
// serial host model that sends command frames
`timescale 1ns/1ps
module spi_host_model (
    output reg sck,
    output reg si,
    output reg cs_n,
    output reg hold_n,
    input wire so_out,
    input wire so_oe_n
);
    initial begin
        sck = 0; si = 0; cs_n = 1; hold_n = 1;
    end
    task frame(input [31:0] tx, input integer n, input integer p,
        output [31:0] rx);
        integer i;
        begin
            rx = 0;
            cs_n = 0;
            #48;
            // msb first, set while clock low
            for (i = n - 1; i >= 0; i--) begin
                si = tx[i];
                if (i == p) begin
                    hold_n = 0; #96 hold_n = 1;
                end
                #24 rx = {rx[30:0], so_oe_n ? 1'bz : so_out};
                sck = 1;
                #24 sck = 0;
            end
            #24 cs_n = 1;
            si = ~si;
            #96;
        end
    endtask
endmodule

// ---- sim/test_spi_pot_command_unit.sv ----
// self-checking bench for the pot command unit
`timescale 1ns/1ps
`include "pot_cmd_map.vh"
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
$display("MISMATCH %s exp %h got %h", n, e, a); end end
module test_spi_pot_command_unit;
    reg clk = 0, rst = 1, wp_n = 1, addr = 1;
    wire sck, si, cs_n, hold_n, so_out, so_oe_n, busy;
    wire [9:0] wq;
    wire [1023:0] taps;
    reg [31:0] rx;
    reg [15:0] rnd = 16'hc502;
    reg [9:0] v;
    integer st [0:3];
    integer wip = 0, n_fail = 0, n_tests = 0, s;
    spi_pot_command_unit #(.NV_CYCLES(2000)) spi_pot_command_unit_i (
        .clk(clk), .rst(rst), .sck(sck), .si(si), .cs_n(cs_n),
        .hold_n(hold_n), .wp_n(wp_n), .slave_addr_bit(addr),
        .so_out(so_out), .so_oe_n(so_oe_n), .write_status_reg(busy),
        .wiper_position_reg(wq), .tap_select(taps));
    spi_host_model spi_host_model_i (.sck(sck), .si(si), .cs_n(cs_n),
        .hold_n(hold_n), .so_out(so_out), .so_oe_n(so_oe_n));
    initial forever #2.5 clk = ~clk;
    function [15:0] lfsr(input [15:0] r);
        lfsr = {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
    endfunction
    // ========================================
    // bus tasks
    task run(input d, input [2:0] op, input [3:0] lo, input [9:0] x,
        input integer n, input integer p);
        @(posedge clk) #1;
        spi_host_model_i.frame({`TYPE_CODE, `ID_FIXED_ZERO, 1'b1, d, op,
            1'b0, lo, 6'h00, x} >> (32 - n), n, p, rx);
    endtask
    task idle;
        integer t;
        for (t = 0; t < 3000 && busy !== 1'b0; t++) @(posedge clk);
        #1;
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // about twice the expected length of all tests
    initial begin
        #200000 n_fail++;
        print_verdict;
    end
    initial begin
        for (s = 0; s < 4; s++) st[s] = 0;
        repeat (10) @(posedge clk);
        #1 rst = 0;
        repeat (6) @(posedge clk);
        `CHK("recall", 10'h000, wq);
        for (s = 0; s < 3; s++) begin
            rnd = lfsr(rnd);
            wip = rnd[9:0];
            run(0, `OP_WRITE_WIPER, 4'h0, rnd[9:0], 32, -1);
            `CHK("wiper", wip[9:0], wq);
            `CHK("taps", 1024'h1 << wip[9:0], taps);
            run(1, `OP_READ_WIPER, 4'h0, 10'h000, 32, -1);
            `CHK("wiper_rd", wip[9:0], rx[9:0]);
            `CHK("so_idle", 16'hzzzz, rx[31:16]);
        end
        $display("end wiper");
        // stored writes, refused work while busy
        for (s = 0; s < 4; s++) begin
            rnd = lfsr(rnd);
            v = rnd[9:0];
            st[s] = v;
            run(0, `OP_WRITE_STORED, {s[1:0], 2'h0}, v, 32, -1);
            `CHK("busy", 1'b1, busy);
            run(1, `OP_STATUS, {2'h0, `STATUS_TAIL}, 10'h000, 32, -1);
            `CHK("status", 1'b1, rx[0]);
            run(0, `OP_WRITE_WIPER, 4'h0, ~v, 32, -1);
            idle;
            `CHK("idle", 1'b0, busy);
            `CHK("wiper_busy", wip[9:0], wq);
            run(1, `OP_READ_STORED, {s[1:0], 2'h0}, 10'h000, 32, -1);
            `CHK("stored", v, rx[9:0]);
        end
        $display("end stored");
        for (s = 0; s < 4; s++) begin
            run(1, `OP_COPY_TO_WIPER, {s[1:0], 2'h0}, 10'h000, 16, -1);
            repeat (60) @(posedge clk);
            wip = st[s];
            `CHK("copy_in", wip[9:0], wq);
        end
        run(0, `OP_WRITE_WIPER, 4'h0, ~wip[9:0], 32, -1);
        wip = ~wip;
        st[2] = wip[9:0];
        run(0, `OP_COPY_TO_STORED, 4'h8, 10'h000, 16, -1);
        `CHK("copy_busy", 1'b1, busy);
        idle;
        run(1, `OP_READ_STORED, 4'h8, 10'h000, 32, -1);
        `CHK("copy_out", wip[9:0], rx[9:0]);
        $display("end copy");
        @(posedge clk) #1 wp_n = 0;
        run(0, `OP_WRITE_STORED, 4'h4, ~st[1][9:0], 32, -1);
        @(posedge clk) #1 wp_n = 1;
        idle;
        run(1, `OP_READ_STORED, 4'h4, 10'h000, 32, -1);
        `CHK("locked", st[1][9:0], rx[9:0]);
        @(posedge clk) #1 addr = 0;
        run(0, `OP_WRITE_WIPER, 4'h0, ~wip[9:0], 32, -1);
        `CHK("addr", wip[9:0], wq);
        run(1, `OP_READ_WIPER, 4'h0, 10'h000, 32, -1);
        `CHK("addr_rd", 32'hzzzzzzzz, rx);
        @(posedge clk) #1 addr = 1;
        rnd = lfsr(rnd);
        wip = rnd[9:0];
        run(0, `OP_WRITE_WIPER, 4'h0, rnd[9:0], 32, 20);
        `CHK("paused", wip[9:0], wq);
        $display("end misc");
        print_verdict;
    end
endmodule
